// ### common/bstt_defines.vh
// Constants for the bus state trace trigger sequencer
// Notes on behaviour
// - A coordinated execute pulse starts an acquisition.
// - Outside until-stop mode, complete only after the trigger is satisfied and memory is filled.
// - With halt-at-trigger, request a processor halt when the trigger fires.
// - Until-stop mode stores until halt or stop; no trigger, halt or rerun.
// - With storage qualifier on, store only matching states.
// - With prestore on, keep the last prestore match before each stored state.
// - Rerun restarts after readout, until stop or a new start.
// - Up to seven ordered terms including trigger; advance only on match.
// - With windowing on, at most four sequence terms in total.
// - Centre position stores states before and after the trigger.
// - Post mode acquires after trigger; pre mode keeps states before it.
// - Trigger fires after the programmed number of qualifier occurrences.
// - With no trigger term, trigger on the first state of any kind.
// - Window open: evaluate sequence and trigger terms and store states.
// - Window closed: no storage or recognition; only the open term is compared.
// - Close term match while open stops storage and recognition.
// - One open term and one close term, each an independent qualifier.
// - Each term matches one value or a range on address, data or status.
// - Without windowing every state is eligible for recognition.
// - The cross trigger line may serve as a qualifier term.
// - Cross trigger qualifier needs line sourced from coax or bus trigger and received.
`ifndef BSTT_DEFINES_VH
`define BSTT_DEFINES_VH
// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define BSTT_A_CTRL    8'h00
`define BSTT_A_STATUS  8'h04
`define BSTT_A_OCC     8'h08
`define BSTT_A_RDPTR   8'h10
`define BSTT_A_RDLO    8'h14
`define BSTT_A_RDHI    8'h18
`define BSTT_A_TERM0   8'h40
// ----------------------------------------------------------------
// Control fields
// ----------------------------------------------------------------
`define BSTT_C_START   0
`define BSTT_C_STOP    1
`define BSTT_C_ONHALT  2
`define BSTT_C_HALTTRG 3
`define BSTT_C_REPEAT  4
`define BSTT_C_STOREQ  5
`define BSTT_C_PRESTO  6
`define BSTT_C_WINDOW  7
`define BSTT_C_POS_LO  8
`define BSTT_C_TRIGEN  10
`define BSTT_C_XSRC    11
`define BSTT_C_XRX     12
`define BSTT_C_SEQ_LO  13
`define BSTT_CTRL_RST  16'h0000
`define BSTT_CTRL_WMSK 16'hFFFC
// Trigger positions
`define BSTT_POS_AFTER  2'h0
`define BSTT_POS_ABOUT  2'h1
`define BSTT_POS_BEFORE 2'h2
// ----------------------------------------------------------------
// Term slots and term configuration fields
// ----------------------------------------------------------------
`define BSTT_NT        11
`define BSTT_T_TRIG    6
`define BSTT_T_STORE   7
`define BSTT_T_PRE     8
`define BSTT_T_OPEN    9
`define BSTT_T_CLOSE   10
`define BSTT_SEQ_MAX   3'h6
`define BSTT_SEQ_WMAX  3'h3
`define BSTT_F_ADDR    2'h0
`define BSTT_F_DATA    2'h1
`define BSTT_F_STAT    2'h2
`define BSTT_TC_RANGE  2
`define BSTT_TC_XTRIG  3
`define BSTT_TC_ANY    4
// ----------------------------------------------------------------
// Trace memory
// ----------------------------------------------------------------
`define BSTT_DEPTH     9'h100
`define BSTT_POST_AFT  9'h0FF
`define BSTT_POST_ABT  9'h080
`endif

// ### src/bstt_qual.v
// One qualifier term compared against the sampled bus state
`include "bstt_defines.vh"
module bstt_qual (
    // Term setup
    input  wire [4:0]  cfg,
    input  wire [31:0] lo,
    input  wire [31:0] hi,
    // Sampled state
    input  wire [31:0] s_addr,
    input  wire [15:0] s_data,
    input  wire [15:0] s_stat,
    input  wire        xtrig,
    // Result
    output reg         match
);
    reg [31:0] val;

    always @* begin
        case (cfg[1:0])
            `BSTT_F_ADDR: val = s_addr;
            `BSTT_F_DATA: val = {16'h0000, s_data};
            `BSTT_F_STAT: val = {16'h0000, s_stat};
            default:      val = s_addr;
        endcase
        if (cfg[`BSTT_TC_ANY])
            match = 1'b1;
        else if (cfg[`BSTT_TC_XTRIG])
            match = xtrig;
        else if (cfg[`BSTT_TC_RANGE])
            match = (val >= lo) && (val <= hi);
        else
            match = (val == lo);
    end
endmodule

// ### src/bstt_core.v
// Trace acquisition controller with Avalon-MM register access
//
// Design decisions made here: the Avalon-MM interface to the registers and the register addresses.
`include "bstt_defines.vh"
module bstt_core (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rst,
    // Avalon-MM slave
    input  wire [7:0]  avs_address,
    input  wire        avs_read,
    input  wire        avs_write,
    input  wire [31:0] avs_writedata,
    output reg  [31:0] avs_readdata,
    output wire        avs_waitrequest,
    // Emulated processor bus state
    input  wire        bus_valid,
    input  wire [31:0] bus_addr,
    input  wire [15:0] bus_data,
    input  wire [15:0] bus_status,
    // Coordination and control
    input  wire        cmb_execute,
    input  wire        proc_halted,
    input  wire        cross_trigger_line,
    output reg         halt_req,
    output reg         trace_complete
);
    // ----------------------------------------------------------------
    // Decode helpers
    // ----------------------------------------------------------------
    function is_term;
        input [7:0] a;
        begin
            is_term = (a >= `BSTT_A_TERM0) && (a[7:4] < 4'h4 + 4'hB)
                      && (a[3:2] != 2'h3);
        end
    endfunction

    function [3:0] term_idx;
        input [7:0] a;
        begin
            term_idx = a[7:4] - 4'h4;
        end
    endfunction

    // ----------------------------------------------------------------
    // Bus handshake
    // ----------------------------------------------------------------
    // Every access waits one cycle so read data can come from flops.
    reg        ack;
    wire       req = avs_read | avs_write;
    wire       wr_acc = avs_write & ack;
    wire       rd_acc = avs_read & ack;
    assign avs_waitrequest = req & ~ack;

    always @(posedge clk_sys) begin
        if (rst)
            ack <= 1'b0;
        else
            ack <= req & ~ack;
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    reg [15:0] ctrl;
    reg [15:0] occ_cfg;
    reg [4:0]  t_cfg [0:`BSTT_NT-1];
    reg [31:0] t_lo  [0:`BSTT_NT-1];
    reg [31:0] t_hi  [0:`BSTT_NT-1];
    integer    i;

    wire       ctrl_wr = wr_acc & (avs_address == `BSTT_A_CTRL);
    wire       start_sw = ctrl_wr & avs_writedata[`BSTT_C_START];
    wire       stop_sw = ctrl_wr & avs_writedata[`BSTT_C_STOP];
    wire [3:0] wti = term_idx(avs_address);

    always @(posedge clk_sys) begin
        if (rst) begin
            ctrl <= `BSTT_CTRL_RST;
            occ_cfg <= 16'h0001;
            for (i = 0; i < `BSTT_NT; i = i + 1) begin
                t_cfg[i] <= 5'h10;
                t_lo[i] <= 32'h00000000;
                t_hi[i] <= 32'h00000000;
            end
        end else if (wr_acc) begin
            if (avs_address == `BSTT_A_CTRL)
                ctrl <= avs_writedata[15:0] & `BSTT_CTRL_WMSK;
            else if (avs_address == `BSTT_A_OCC)
                occ_cfg <= avs_writedata[15:0];
            else if (is_term(avs_address)) begin
                case (avs_address[3:2])
                    2'h0:    t_cfg[wti] <= avs_writedata[4:0];
                    2'h1:    t_lo[wti] <= avs_writedata;
                    default: t_hi[wti] <= avs_writedata;
                endcase
            end
        end
    end

    // ----------------------------------------------------------------
    // Mode decode
    // ----------------------------------------------------------------
    // Until-stop mode overrides trigger, halt and rerun settings.
    wire       on_halt = ctrl[`BSTT_C_ONHALT];
    wire       trig_en = ctrl[`BSTT_C_TRIGEN] & ~on_halt;
    wire       halt_en = ctrl[`BSTT_C_HALTTRG] & ~on_halt;
    wire       rpt_en = ctrl[`BSTT_C_REPEAT] & ~on_halt;
    wire       store_q = ctrl[`BSTT_C_STOREQ];
    wire       pre_en = ctrl[`BSTT_C_PRESTO];
    wire       win_en = ctrl[`BSTT_C_WINDOW];
    wire [1:0] pos = ctrl[`BSTT_C_POS_LO+1:`BSTT_C_POS_LO];
    wire [2:0] seq_req = ctrl[`BSTT_C_SEQ_LO+2:`BSTT_C_SEQ_LO];
    wire [2:0] seq_lim = win_en ? `BSTT_SEQ_WMAX : `BSTT_SEQ_MAX;
    wire [2:0] seq_n = (seq_req > seq_lim) ? seq_lim : seq_req;
    // The line qualifies only when routed from a source and received.
    wire       x_ok = ctrl[`BSTT_C_XSRC] & ctrl[`BSTT_C_XRX]
                      & cross_trigger_line;

    // ----------------------------------------------------------------
    // Qualifier terms
    // ----------------------------------------------------------------
    wire [`BSTT_NT-1:0] m;
    genvar g;
    generate
        for (g = 0; g < `BSTT_NT; g = g + 1) begin : qual
            bstt_qual u_q (
                .cfg    (t_cfg[g]),
                .lo     (t_lo[g]),
                .hi     (t_hi[g]),
                .s_addr (bus_addr),
                .s_data (bus_data),
                .s_stat (bus_status),
                .xtrig  (x_ok),
                .match  (m[g])
            );
        end
    endgenerate

    // ----------------------------------------------------------------
    // Acquisition state
    // ----------------------------------------------------------------
    reg        running;
    reg        triggered;
    reg        win_open;
    reg [2:0]  seq_idx;
    reg [15:0] occ_left;
    reg [8:0]  post_left;
    reg [8:0]  cnt;
    reg [7:0]  wp;
    reg [7:0]  rd_ptr;
    reg        pre_valid;
    reg [63:0] pre_buf;
    reg [63:0] mem [0:255];

    wire [63:0] cur = {bus_addr, bus_data, bus_status};
    wire        smp = running & bus_valid;
    wire        full = (cnt == `BSTT_DEPTH);

    // Recognition gate: the close match itself is already excluded.
    wire rec = ~win_en | (win_open & ~m[`BSTT_T_CLOSE]);
    wire hunt = smp & rec & ~triggered;
    wire seq_hit = hunt & (seq_idx < seq_n) & m[seq_idx];
    wire trig_cand = hunt & (seq_idx >= seq_n) & ~on_halt
                     & (~trig_en | m[`BSTT_T_TRIG]);
    wire fire = trig_cand & (~trig_en | (occ_left <= 16'h0001));
    wire st_ok = smp & rec & (~store_q | m[`BSTT_T_STORE]);
    wire pre_hit = smp & rec & pre_en & m[`BSTT_T_PRE] & ~st_ok;
    wire two_wr = st_ok & pre_en & pre_valid;
    wire [8:0] nw = st_ok ? (two_wr ? 9'h002 : 9'h001) : 9'h000;
    wire [9:0] cnt_sum = {1'b0, cnt} + {1'b0, nw};
    wire [8:0] cnt_nx = (cnt_sum > {1'b0, `BSTT_DEPTH}) ? `BSTT_DEPTH
                        : cnt_sum[8:0];
    wire [8:0] fill_need = `BSTT_DEPTH - cnt_nx;
    reg  [8:0] pos_need;

    always @* begin
        case (pos)
            `BSTT_POS_AFTER:  pos_need = `BSTT_POST_AFT;
            `BSTT_POS_ABOUT:  pos_need = `BSTT_POST_ABT;
            `BSTT_POS_BEFORE: pos_need = 9'h000;
            default:          pos_need = `BSTT_POST_AFT;
        endcase
    end

    // A short pre-trigger record is topped up so memory is always full.
    wire [8:0] post_init = (pos_need > fill_need) ? pos_need : fill_need;
    wire [8:0] post_dec = (post_left > nw) ? post_left - nw : 9'h000;
    wire       post_done = triggered & (post_left == 9'h000);
    wire       halt_done = on_halt & (proc_halted | stop_sw);

    // Readout of the last stored entry re-arms a rerun.
    wire       rd_last = rd_acc & (avs_address == `BSTT_A_RDHI)
                         & ({1'b0, rd_ptr} + 9'h001 >= cnt);
    wire       rerun = trace_complete & rpt_en & rd_last;
    wire       start = start_sw | cmb_execute | rerun;

    always @(posedge clk_sys) begin
        if (rst) begin
            running <= 1'b0;
            triggered <= 1'b0;
            win_open <= 1'b0;
            seq_idx <= 3'h0;
            occ_left <= 16'h0000;
            post_left <= 9'h000;
            cnt <= 9'h000;
            wp <= 8'h00;
            pre_valid <= 1'b0;
            pre_buf <= 64'h0000000000000000;
            halt_req <= 1'b0;
            trace_complete <= 1'b0;
        end else if (start) begin
            running <= 1'b1;
            triggered <= 1'b0;
            win_open <= 1'b0;
            seq_idx <= 3'h0;
            occ_left <= occ_cfg;
            post_left <= 9'h000;
            cnt <= 9'h000;
            wp <= 8'h00;
            pre_valid <= 1'b0;
            halt_req <= 1'b0;
            trace_complete <= 1'b0;
        end else if (stop_sw & ~on_halt) begin
            running <= 1'b0;
        end else if (running) begin
            if (smp & win_en) begin
                if (~win_open & m[`BSTT_T_OPEN])
                    win_open <= 1'b1;
                else if (win_open & m[`BSTT_T_CLOSE])
                    win_open <= 1'b0;
            end
            if (seq_hit)
                seq_idx <= seq_idx + 3'h1;
            if (trig_cand & ~fire)
                occ_left <= occ_left - 16'h0001;
            if (pre_hit) begin
                pre_valid <= 1'b1;
                pre_buf <= cur;
            end else if (st_ok)
                pre_valid <= 1'b0;
            if (st_ok & ~post_done) begin
                wp <= wp + nw[7:0];
                cnt <= cnt_nx;
            end
            if (fire) begin
                triggered <= 1'b1;
                post_left <= post_init;
                if (halt_en)
                    halt_req <= 1'b1;
            end else if (triggered)
                post_left <= post_dec;
            if (post_done | halt_done) begin
                running <= 1'b0;
                trace_complete <= 1'b1;
            end
        end
    end

    // ----------------------------------------------------------------
    // Trace memory
    // ----------------------------------------------------------------
    // Prestore entry and stored state may land in one cycle: two write ports.
    always @(posedge clk_sys) begin
        if (running & st_ok & ~post_done) begin
            if (two_wr) begin
                mem[wp] <= pre_buf;
                mem[wp + 8'h01] <= cur;
            end else
                mem[wp] <= cur;
        end
    end

    // ----------------------------------------------------------------
    // Readout
    // ----------------------------------------------------------------
    wire [7:0]  oldest = full ? wp : 8'h00;
    wire [7:0]  ra = oldest + rd_ptr;
    wire [63:0] rd_ent = mem[ra];

    always @(posedge clk_sys) begin
        if (rst)
            rd_ptr <= 8'h00;
        else if (start)
            rd_ptr <= 8'h00;
        else if (wr_acc & (avs_address == `BSTT_A_RDPTR))
            rd_ptr <= avs_writedata[7:0];
        else if (rd_acc & (avs_address == `BSTT_A_RDHI))
            rd_ptr <= rd_ptr + 8'h01;
    end

    wire [31:0] status_w = {7'h00, cnt, 8'h00, halt_req, seq_idx,
                            win_open, triggered, trace_complete, running};
    wire [3:0]  rti = term_idx(avs_address);

    always @(posedge clk_sys) begin
        if (rst)
            avs_readdata <= 32'h00000000;
        else if (avs_read & ~ack) begin
            if (avs_address == `BSTT_A_CTRL)
                avs_readdata <= {16'h0000, ctrl};
            else if (avs_address == `BSTT_A_STATUS)
                avs_readdata <= status_w;
            else if (avs_address == `BSTT_A_OCC)
                avs_readdata <= {16'h0000, occ_cfg};
            else if (avs_address == `BSTT_A_RDPTR)
                avs_readdata <= {24'h000000, rd_ptr};
            else if (avs_address == `BSTT_A_RDLO)
                avs_readdata <= rd_ent[31:0];
            else if (avs_address == `BSTT_A_RDHI)
                avs_readdata <= rd_ent[63:32];
            else if (is_term(avs_address)) begin
                case (avs_address[3:2])
                    2'h0:    avs_readdata <= {27'h0000000, t_cfg[rti]};
                    2'h1:    avs_readdata <= t_lo[rti];
                    default: avs_readdata <= t_hi[rti];
                endcase
            end else
                avs_readdata <= 32'h00000000;
        end
    end
endmodule

// ### verif/bstt_checker.sv
// Port-level assertions for the trace trigger sequencer
module bstt_checker (
    // Clock and reset
    input wire        clk_sys,
    input wire        rst,
    // Register bus
    input wire [7:0]  avs_address,
    input wire        avs_read,
    input wire        avs_write,
    input wire [31:0] avs_writedata,
    input wire [31:0] avs_readdata,
    input wire        avs_waitrequest,
    // Processor bus and coordination
    input wire        bus_valid,
    input wire [31:0] bus_addr,
    input wire [15:0] bus_data,
    input wire [15:0] bus_status,
    input wire        cmb_execute,
    input wire        proc_halted,
    input wire        cross_trigger_line,
    input wire        halt_req,
    input wire        trace_complete
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    AST_IDLE_NOWAIT: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
        else $error("waitrequest high with no request");
    AST_ONE_WAIT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("register access took more than one wait cycle");
    AST_START_CLEARS: assert property (cmb_execute |=> !trace_complete && !halt_req)
        else $error("start did not clear complete and halt");
    AST_CMPL_HOLD: assert property (trace_complete && !cmb_execute && !avs_write && !avs_read |=> trace_complete)
        else $error("complete dropped without a start");
    AST_HALT_HOLD: assert property (halt_req && !cmb_execute && !avs_write && !avs_read |=> halt_req)
        else $error("halt request dropped without a start");
    AST_CMPL_CAUSE: assert property ($rose(trace_complete) |-> $past(proc_halted || avs_write) || $past(bus_valid, 2))
        else $error("complete rose with no state, halt or stop");
    AST_HALT_CAUSE: assert property ($rose(halt_req) |-> $past(bus_valid))
        else $error("halt request rose with no sampled state");
    AST_RST_VALUES: assert property (@(posedge clk_sys) disable iff (1'b0)
        rst |=> avs_readdata == 32'h0 && !halt_req && !trace_complete)
        else $error("outputs not cleared by reset");
endmodule
bind bstt_core bstt_checker u_chk (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .bus_valid(bus_valid), .bus_addr(bus_addr), .bus_data(bus_data),
    .bus_status(bus_status), .cmb_execute(cmb_execute), .proc_halted(proc_halted),
    .cross_trigger_line(cross_trigger_line), .halt_req(halt_req), .trace_complete(trace_complete));

// ### verif/bstt_proc_model.sv
// Emulated processor bus model that issues numbered bus states
module bstt_proc_model (
    // Clock and reset
    input  wire         clk_sys,
    input  wire         rst,
    // Bench control
    input  wire         run,
    input  wire         slow,
    // Processor bus
    input  wire         halt_req,
    output logic        bus_valid,
    output logic [31:0] bus_addr,
    output logic [15:0] bus_data,
    output logic [15:0] bus_status,
    output logic        proc_halted
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] count;
    logic        phase;
    logic [1:0]  halt_dly;
    // Between states the lines show the inverse, so a stale state never looks valid
    assign bus_addr   = bus_valid ? count : ~count;
    assign bus_data   = bus_valid ? ~count[15:0] : count[15:0];
    assign bus_status = bus_valid ? 16'h00A5 : 16'hFF5A;
    always @(posedge clk_sys) begin
        if (rst || !run) begin
            count       <= 32'h0;
            phase       <= 1'b0;
            bus_valid   <= 1'b0;
            halt_dly    <= 2'h0;
            proc_halted <= 1'b0;
        end else begin
            if (bus_valid)
                count <= count + 32'h1;
            phase       <= ~phase;
            bus_valid   <= !proc_halted && (!slow || phase);
            halt_dly    <= {halt_dly[0], halt_req};
            proc_halted <= proc_halted | halt_dly[1];
        end
    end
endmodule

// ### verif/testbench.sv
// Self-checking bench for the trace trigger sequencer
`include "bstt_defines.vh"
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk_sys, rst, avs_read, avs_write, cmb_execute, cross_trigger_line, run, slow;
    logic [7:0]  avs_address;
    logic [31:0] avs_writedata;
    wire  [31:0] avs_readdata, bus_addr;
    wire  [15:0] bus_data, bus_status;
    wire         avs_waitrequest, bus_valid, proc_halted, halt_req, trace_complete;
    int          num_errors, n_compared;

    bstt_core dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .bus_valid(bus_valid), .bus_addr(bus_addr), .bus_data(bus_data),
        .bus_status(bus_status), .cmb_execute(cmb_execute), .proc_halted(proc_halted),
        .cross_trigger_line(cross_trigger_line), .halt_req(halt_req), .trace_complete(trace_complete));
    bstt_proc_model u_proc (.clk_sys(clk_sys), .rst(rst), .run(run), .slow(slow), .halt_req(halt_req),
        .bus_valid(bus_valid), .bus_addr(bus_addr), .bus_data(bus_data), .bus_status(bus_status),
        .proc_halted(proc_halted));

    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task complete_run;
        $display("compared %0d mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task check(input [31:0] seen, input [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task wr(input [7:0] a, input [31:0] d);
        @(posedge clk_sys);
        avs_address   <= a;
        avs_writedata <= d;
        avs_write     <= 1'b1;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
        avs_write <= 1'b0;
    endtask
    task rd(input [7:0] a, output [31:0] d);
        @(posedge clk_sys);
        avs_address <= a;
        avs_read    <= 1'b1;
        @(posedge clk_sys);
        while (avs_waitrequest !== 1'b0) @(posedge clk_sys);
        d = avs_readdata;
        avs_read <= 1'b0;
    endtask
    task wterm(input [3:0] n, input [31:0] cfg, input [31:0] lo, input [31:0] hi);
        wr(`BSTT_A_TERM0 + {n, 4'h0}, cfg);
        wr(`BSTT_A_TERM0 + {n, 4'h4}, lo);
        wr(`BSTT_A_TERM0 + {n, 4'h8}, hi);
    endtask
    task entry(input [8:0] idx, output [31:0] a);
        wr(`BSTT_A_RDPTR, {23'h0, idx});
        rd(`BSTT_A_RDHI, a);
    endtask
    // Bounded wait: a missing completion adds one to the error count
    task wait_done;
        int i;
        i = 0;
        while (trace_complete !== 1'b1 && i < 4000) begin
            @(posedge clk_sys);
            i++;
        end
        if (i >= 4000)
            num_errors++;
    endtask
    task wait_states(input int n);
        int i;
        i = 0;
        while (i < n) begin
            @(posedge clk_sys);
            if (bus_valid === 1'b1)
                i++;
        end
    endtask
    task go(input [31:0] ctrl);
        @(posedge clk_sys);
        run <= 1'b0;
        wr(`BSTT_A_CTRL, ctrl | 32'h1);
        @(posedge clk_sys);
        run <= 1'b1;
    endtask

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task t_regs;
        logic [31:0] v;
        rd(`BSTT_A_CTRL, v);    check(v, 32'h0);
        rd(`BSTT_A_OCC, v);     check(v, 32'h1);
        rd(`BSTT_A_TERM0, v);   check(v, 32'h10);
        rd(8'h3C, v);           check(v, 32'h0);
        wr(`BSTT_A_CTRL, 32'h2A);
        rd(`BSTT_A_CTRL, v);    check(v, 32'h28);
        wr(`BSTT_A_CTRL, 32'h0);
        $display("test regs done");
    endtask
    // Default setup started from the coordination bus
    task t_exec;
        logic [31:0] v;
        slow <= 1'b1;
        run  <= 1'b0;
        @(posedge clk_sys) cmb_execute <= 1'b1;
        @(posedge clk_sys) cmb_execute <= 1'b0;
        @(posedge clk_sys) run <= 1'b1;
        wait_done();
        check(trace_complete, 32'h1);
        check(halt_req, 32'h0);
        rd(`BSTT_A_STATUS, v);
        check(v[24:16], 32'h100);
        check(v[2], 32'h1);
        entry(9'h0, v);   check(v, 32'h0);
        entry(9'hFF, v);  check(v, 32'hFF);
        $display("test exec done");
    endtask
    // Trigger position, occurrence count and halt at trigger
    task t_pos;
        logic [31:0] v, old;
        int k;
        slow <= 1'b0;
        wterm(4'h6, 32'h4, 32'h100, 32'h1FF);
        for (k = 0; k < 3; k++) begin
            old = (k == 0) ? 32'h100 : (k == 1) ? 32'h81 : 32'h3;
            wr(`BSTT_A_OCC, (k == 2) ? 32'h3 : 32'h1);
            go(32'h400 | (k << 8) | ((k == 2) ? 32'h8 : 32'h0));
            wait_done();
            check(trace_complete, 32'h1);
            entry(9'h0, v);   check(v, old);
            entry(9'hFF, v);  check(v, old + 32'hFF);
            check(halt_req, (k == 2) ? 32'h1 : 32'h0);
        end
        check(v, 32'h102);
        $display("test position done");
    endtask
    // Capture until stop with a storage qualifier range
    task t_store;
        logic [31:0] v;
        wterm(4'h7, 32'h4, 32'h200, 32'h2FF);
        go(32'h24);
        wait_states(32'h310);
        check(trace_complete, 32'h0);
        wr(`BSTT_A_CTRL, 32'h26);
        wait_done();
        check(trace_complete, 32'h1);
        rd(`BSTT_A_STATUS, v);
        check(v[24:16], 32'h100);
        entry(9'h0, v);   check(v, 32'h200);
        entry(9'hFF, v);  check(v, 32'h2FF);
        $display("test store done");
    endtask
    // Window opened and closed by two different address terms
    task t_window;
        logic [31:0] v;
        wterm(4'h9, 32'h0, 32'h40, 32'h40);
        wterm(4'hA, 32'h0, 32'h60, 32'h60);
        go(32'h84);
        wait_states(32'h80);
        rd(`BSTT_A_STATUS, v);
        check(v[3], 32'h0);
        wr(`BSTT_A_CTRL, 32'h86);
        wait_done();
        rd(`BSTT_A_STATUS, v);
        check(v[24:16], 32'h1F);
        entry(9'h0, v);   check(v, 32'h41);
        entry(9'h1E, v);  check(v, 32'h5F);
        $display("test window done");
    endtask
    // Sequence term ahead of the trigger, then prestore ahead of stored states
    task t_seq;
        logic [31:0] v;
        wterm(4'h0, 32'h0, 32'h150, 32'h0);
        go(32'h2600);
        wait_done();
        entry(9'hFF, v);  check(v, 32'h153);
        wterm(4'h7, 32'h4, 32'h200, 32'h20F);
        go(32'h64);
        wait_states(32'h220);
        wr(`BSTT_A_CTRL, 32'h66);
        wait_done();
        entry(9'h0, v);   check(v, 32'h1FF);
        entry(9'h1, v);   check(v, 32'h200);
        $display("test seq done");
    endtask

    // ----------------------------------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------------------------------
    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (60000) @(posedge clk_sys);
        num_errors++;
        $display("watchdog expired");
        complete_run();
    end
    initial begin
        num_errors = 0;
        n_compared = 0;
        rst = 1'b1;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 8'h0;
        avs_writedata = 32'h0;
        cmb_execute = 1'b0;
        cross_trigger_line = 1'b0;
        run = 1'b0;
        slow = 1'b0;
        repeat (12) @(posedge clk_sys);
        rst <= 1'b0;
        t_regs();
        t_exec();
        t_pos();
        t_store();
        t_window();
        t_seq();
        complete_run();
    end
endmodule
